// ---- bench/module_reset_and_strap_latch_tb.sv ----
`timescale 1ns/1ns
module module_reset_and_strap_latch_tb import mrsl_pkg::*;;
	localparam int PCYC = 20;
	localparam int ECYC = 8;
	logic sys_clk = 1'h0, reset = 1'h1;
	logic [AW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdData;
	logic [3:0] s_axi_wstrb = 4'hF, hardStraps, hardStrapPins = 4'hA;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, loaderValid, digitalReset, loaderStart;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp, ledFunction;
	logic autoMdixStrapPin = 1'h1, eepromPresent = 1'h0, reloadCmd = 1'h0;
	logic [SS_W-1:0] loaderStraps;
	logic [N_PORT-1:0] portPowerDown = 2'h0;
	logic [N_MOD-1:0] moduleReset;
	logic [LED_N-1:0] ledEnable;
	logic strapsLatched, port1AutonegEn, port1AutoMdix, port1CrossMdix;
	int fail_count = 0, n_tests = 0, nLoad = 0;

	mrsl_top #(.HS_W(4), .PORT_RST_CYCLES(PCYC), .EMU_RST_CYCLES(ECYC)) dut (
		.sys_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .autoMdixStrapPin, .hardStrapPins,
		.eepromPresent, .reloadCmd, .loaderValid, .loaderStraps,
		.digitalReset, .loaderStart, .portPowerDown, .moduleReset,
		.strapsLatched, .hardStraps, .ledEnable, .ledFunction,
		.port1AutonegEn, .port1AutoMdix, .port1CrossMdix);
	mrsl_loader_model lm (.sys_clk, .reset, .loaderStart, .eepromPresent,
		.loaderValid, .loaderStraps);

	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (loaderStart) nLoad++;

	// =========
	// reporting
	task results();
		if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s exp %h got %h", nm, exp, got);
		end
	endtask : check
	task hang();
		fail_count++;
		results();
	endtask : hang
	// =========
	// bus master; the opening edge keeps two tasks off one time step
	task wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (i = 0; i < 50; i++) begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
		if (i == 50) hang();
	endtask : wr
	task rd(input logic [7:0] a);
		int i;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (i = 0; i < 50; i++) begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		rdData = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
		if (i == 50) hang();
	endtask : rd
	task poll(input logic [7:0] a, input int b);
		int i;
		for (i = 0; i < 60; i++) begin
			rd(a);
			if (rdData[b] === 1'h0) break;
		end
		if (i == 60) hang();
	endtask : poll
	// =========
	// scenarios
	task t_straps();
		check("hardStraps", hardStraps, 32'hA);
		check("autoMdix", port1AutoMdix, 32'h1);
		rd(ADDR_HARDWARE_CONFIGURATION_REGISTER);
		check("hwCfg", rdData, 32'h3);
		rd(ADDR_LED_CONFIGURATION_REGISTER);
		check("ledCfg", rdData, 32'h3F);
		rd(ADDR_BASIC_P1);
		check("basicP1", rdData, 32'h1000);
	endtask : t_straps
	task t_mod(input int k, input logic viaBasic);
		logic [7:0] ba;
		int n;
		ba = ADDR_BASIC_P1 + 8'(4 * k);
		n = nLoad;
		if (viaBasic) wr(ba, 32'h8000);
		else wr(ADDR_RESET_CONTROL_REGISTER, 32'h1 << (k + 1));
		rd(viaBasic ? ADDR_RESET_CONTROL_REGISTER : ba);
		check("twinBit", rdData[viaBasic ? k + 1 : 15], 32'h1);
		check("modRst", moduleReset, 32'h1 << k);
		poll(viaBasic ? ba : ADDR_RESET_CONTROL_REGISTER, viaBasic ? 15 : k + 1);
		rd(viaBasic ? ADDR_RESET_CONTROL_REGISTER : ba);
		check("twinClr", rdData[viaBasic ? k + 1 : 15], 32'h0);
		check("modIdle", moduleReset, 32'h0);
		check("noLoad", nLoad, n);
		check("noRelatch", hardStraps, 32'hA);
	endtask : t_mod
	task t_keep();
		wr(ADDR_BASIC_P1, 32'h1080);
		wr(ADDR_BASIC_P1, 32'h9080);
		wr(ADDR_RESET_CONTROL_REGISTER, 32'h0);
		rd(ADDR_RESET_CONTROL_REGISTER);
		check("zeroNoAbort", rdData, 32'h2);
		poll(ADDR_BASIC_P1, 15);
		rd(ADDR_BASIC_P1);
		check("keepBit", rdData, 32'h1080);
		wr(ADDR_RESET_CONTROL_REGISTER, 32'h2);
		poll(ADDR_RESET_CONTROL_REGISTER, 1);
		rd(ADDR_BASIC_P1);
		check("fullDefault", rdData, 32'h1000);
	endtask : t_keep
	task t_wake();
		wr(ADDR_BASIC_P2, 32'h0001);
		portPowerDown <= 2'h2;
		repeat (3) @(posedge sys_clk);
		portPowerDown <= 2'h0;
		repeat (2) @(posedge sys_clk);
		check("wake", moduleReset, 32'h2);
		poll(ADDR_BASIC_P2, 15);
		rd(ADDR_BASIC_P2);
		check("wakeKeeps", rdData, 32'h1);
	endtask : t_wake
	task t_loader();
		int i;
		int n;
		n = nLoad;
		eepromPresent <= 1'h1;
		wr(ADDR_RESET_CONTROL_REGISTER, 32'h1);
		for (i = 0; i < 40 && !loaderValid; i++) @(posedge sys_clk);
		if (i == 40) hang();
		repeat (3) @(posedge sys_clk);
		check("digLoad", nLoad, n + 1);
		check("digNoPhy", moduleReset, 32'h0);
		check("ovrLed", {ledFunction, ledEnable}, 32'h95);
		check("ovrAn", port1AutonegEn, 32'h0);
		check("ovrAuto", port1AutoMdix, 32'h0);
		check("ovrCross", port1CrossMdix, 32'h1);
		check("hardKept", hardStraps, 32'hA);
		autoMdixStrapPin <= 1'h0;
		hardStrapPins <= 4'h5;
		eepromPresent <= 1'h0;
		reloadCmd <= 1'h1;
		@(posedge sys_clk);
		reloadCmd <= 1'h0;
		repeat (4) @(posedge sys_clk);
		check("rstLed", {ledFunction, ledEnable}, 32'h3F);
		check("rstCross", port1CrossMdix, 32'h0);
		check("noResample", port1AutoMdix, 32'h1);
		check("hardNoResample", hardStraps, 32'hA);
	endtask : t_loader
	task t_unmapped();
		wr(8'h40, 32'hE);
		check("wrResp", resp, 32'h2);
		check("wrNoEffect", moduleReset, 32'h0);
		rd(8'h40);
		check("rdResp", resp, 32'h2);
		check("rdData", rdData, 32'h0);
	endtask : t_unmapped
	task t_relatch();
		reset <= 1'h1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'h0;
		repeat (8) @(posedge sys_clk);
		check("relatchHard", hardStraps, 32'h5);
		check("relatchAuto", port1AutoMdix, 32'h0);
	endtask : t_relatch

	initial begin
		repeat (2) @(posedge sys_clk);
		reset <= 1'h0;
		repeat (6) @(posedge sys_clk);
		t_straps();
		for (int k = 0; k < N_MOD; k++) begin
			t_mod(k, 1'h0);
			t_mod(k, 1'h1);
		end
		t_keep();
		t_wake();
		t_loader();
		t_unmapped();
		t_relatch();
		results();
	end
endmodule : module_reset_and_strap_latch_tb

// ---- bench/mrsl_loader_model.sv ----
`timescale 1ns/1ns
module mrsl_loader_model import mrsl_pkg::*; #(
	parameter logic [SS_W-1:0] IMAGE = 11'h295
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// loader handshake
	input wire logic loaderStart,
	input wire logic eepromPresent,
	output logic loaderValid,
	output logic [SS_W-1:0] loaderStraps
);
	logic [2:0] wait_q;
	// =========
	// image delivery, only soft straps travel
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wait_q <= 3'h0;
			loaderValid <= 1'h0;
		end else begin
			loaderValid <= wait_q == 3'h1;
			if (loaderStart && eepromPresent)
				wait_q <= 3'h4;
			else if (wait_q != 3'h0)
				wait_q <= wait_q - 3'h1;
		end
	end
	// unqualified strap bus shows junk so a stale capture is caught
	assign loaderStraps = loaderValid ? IMAGE : ~IMAGE;
endmodule : mrsl_loader_model

// ---- bench/mrsl_top_checker.sv ----
`timescale 1ns/1ns
module mrsl_top_checker import mrsl_pkg::*; #(
	parameter int HS_W = 4,
	parameter int PORT_RST_CYCLES = PORT_RST_CYC,
	parameter int EMU_RST_CYCLES = EMU_RST_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// watched ports
	input wire logic [N_PORT-1:0] portPowerDown,
	input wire logic [N_MOD-1:0] moduleReset,
	input wire logic reloadCmd,
	input wire logic digitalReset,
	input wire logic loaderStart,
	input wire logic strapsLatched,
	input wire logic [HS_W-1:0] hardStraps,
	input wire logic [LED_N-1:0] ledEnable,
	input wire logic [1:0] ledFunction,
	input wire logic port1AutonegEn
);
	logic [15:0] p1Cnt_q;
	logic [15:0] emuCnt_q;
	// =========
	// reset length counters, too long to unroll as repetitions
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			p1Cnt_q <= 16'h0000;
			emuCnt_q <= 16'h0000;
		end else begin
			p1Cnt_q <= moduleReset[MOD_P1] ? p1Cnt_q + 16'h0001 : 16'h0000;
			emuCnt_q <= moduleReset[MOD_EMU] ? emuCnt_q + 16'h0001 : 16'h0000;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// =========
	// properties
	property p_wake;
		$fell(portPowerDown[MOD_P2]) && !moduleReset[MOD_P2] |=>
			moduleReset[MOD_P2];
	endproperty
	a_wake: assert property (p_wake)
		else $error("no wake reset");
	property p_port_len;
		$fell(moduleReset[MOD_P1]) |-> p1Cnt_q == 16'(PORT_RST_CYCLES);
	endproperty
	a_port_len: assert property (p_port_len)
		else $error("port reset length");
	property p_emu_len;
		$fell(moduleReset[MOD_EMU]) |-> emuCnt_q == 16'(EMU_RST_CYCLES);
	endproperty
	a_emu_len: assert property (p_emu_len)
		else $error("emulated reset length");
	property p_emu_alone;
		$rose(moduleReset[MOD_EMU]) |-> $stable(moduleReset[1:0]);
	endproperty
	a_emu_alone: assert property (p_emu_alone)
		else $error("emulated reset spread");
	property p_load_cause;
		loaderStart |-> digitalReset || $past(reloadCmd);
	endproperty
	a_load_cause: assert property (p_load_cause)
		else $error("loader started alone");
	property p_digital_load;
		digitalReset |-> loaderStart;
	endproperty
	a_digital_load: assert property (p_digital_load)
		else $error("digital reset no loader");
	property p_hard_hold;
		strapsLatched && $past(strapsLatched) |-> $stable(hardStraps);
	endproperty
	a_hard_hold: assert property (p_hard_hold)
		else $error("hard straps moved");
	property p_defaults;
		$rose(strapsLatched) |=> ##1 ledEnable == 6'h3F &&
			ledFunction == 2'h0 && port1AutonegEn;
	endproperty
	a_defaults: assert property (p_defaults)
		else $error("strap defaults wrong");
endmodule : mrsl_top_checker

bind mrsl_top mrsl_top_checker #(
	.HS_W(HS_W),
	.PORT_RST_CYCLES(PORT_RST_CYCLES),
	.EMU_RST_CYCLES(EMU_RST_CYCLES)
) chk (.sys_clk(sys_clk), .reset(reset), .portPowerDown(portPowerDown),
	.moduleReset(moduleReset), .reloadCmd(reloadCmd),
	.digitalReset(digitalReset), .loaderStart(loaderStart),
	.strapsLatched(strapsLatched), .hardStraps(hardStraps),
	.ledEnable(ledEnable), .ledFunction(ledFunction),
	.port1AutonegEn(port1AutonegEn));

// ---- pkg/mrsl_pkg.sv ----
// ============================================================
// module reset and strap latch constants
package mrsl_pkg;

	// ============================================================
	// timing
	localparam int CLK_HZ = 10_000_000;
	localparam int CLK_PER_US = CLK_HZ / 1_000_000;
	localparam int PORT_RST_US = 110;
	localparam int EMU_RST_US = 1;
	localparam int PORT_RST_CYC = PORT_RST_US * CLK_PER_US;
	localparam int EMU_RST_CYC = EMU_RST_US * CLK_PER_US;
	localparam int RST_CNT_W = 11;
	// cycles after chip reset release before straps are captured
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	// ============================================================
	// modules reset individually; several can run at once
	localparam int N_MOD = 3;
	localparam int MOD_P1 = 0;
	localparam int MOD_P2 = 1;
	localparam int MOD_EMU = 2;
	localparam int N_PORT = 2;

	// ============================================================
	// register byte offsets
	localparam int AW = 8;
	localparam logic [7:0] ADDR_RESET_CONTROL_REGISTER = 8'h00;
	localparam logic [7:0] ADDR_BASIC_P1 = 8'h04;
	localparam logic [7:0] ADDR_BASIC_P2 = 8'h08;
	localparam logic [7:0] ADDR_BASIC_EMU = 8'h0C;
	localparam logic [7:0] ADDR_HARDWARE_CONFIGURATION_REGISTER = 8'h10;
	localparam logic [7:0] ADDR_LED_CONFIGURATION_REGISTER = 8'h14;
	localparam logic [7:0] ADDR_SPEC_CTL_P1 = 8'h18;

	// ============================================================
	// field positions and defaults
	localparam int RC_DIGITAL = 0;
	localparam int RC_MOD_LSB = 1;
	localparam int BC_RESET = 15;
	localparam int BC_AUTONEG = 12;
	localparam logic [15:0] BC_DEFAULT = 16'h0000;
	localparam logic [15:0] BC_SURVIVES_SOFT_RESET_ATTRIBUTE_MASK = 16'h0080;
	localparam int HC_AMDIX1 = 0;
	localparam int HC_LATCHED = 1;
	localparam int LC_EN_LSB = 0;
	localparam int LC_FUN_LSB = 8;
	localparam int SC_STRAPCTL = 15;
	localparam int SC_AUTO = 14;
	localparam int SC_CROSS = 13;
	localparam logic [15:0] SC_DEFAULT = 16'h8000;

	// ============================================================
	// soft strap vector layout and tie-off values
	localparam int LED_N = 6;
	localparam int SS_LED_ENABLE_BITS = 0;
	localparam int SS_LED_FUNCTION_FIELD = 6;
	localparam int SS_AMDIX1 = 8;
	localparam int SS_MMDIX1 = 9;
	localparam int SS_AN1 = 10;
	localparam int SS_W = 11;
	localparam logic [10:0] SS_TIEOFF = 11'h43F;

	// ============================================================
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		CAUSE_FULL,
		CAUSE_SOFT,
		CAUSE_WAKE
	} mrsl_cause_t;

endpackage : mrsl_pkg

// ---- rtl/mrsl_top.sv ----
`timescale 1ns/1ns
// Overview of operation
// - a module reset drives only that module's own reset output
// - module resets never re-latch straps nor start the loader
// - port 2 resets on its control bit or basic bit; both self-clear
// - port 1 resets on its control bit or basic bit; both self-clear
// - port reset bits clear 110 us after the reset starts
// - leaving power-down resets a port without reloading its registers
// - basic-bit reset keeps bits that survive soft resets
// - emulated port resets on either of its bits, nothing else touched
// - emulated port reset bits clear 1 us after the reset starts
// - hard and soft straps latch only on chip reset release
// - loader may override soft straps, never hard straps
// - soft straps without a pin use a fixed tie-off value
// - straps load register defaults directly or combined with other state
// - digital reset or reload without eeprom restores latched soft straps
// - digital reset or reload never resamples strap pins
// - led enable straps default the six led enable bits, each one
// - led function straps default the led function field to 00
// - port 1 auto crossover strap shows in hardware config register
// - strap control with auto strap low: manual strap picks mdi or mdix
// - port 1 autoneg strap defaults the autoneg enable bit
// - digital reset pulses sub-module reset and starts the loader
module mrsl_top import mrsl_pkg::*; #(
	parameter int HS_W = 4,
	parameter int PORT_RST_CYCLES = PORT_RST_CYC,
	parameter int EMU_RST_CYCLES = EMU_RST_CYC
) (
	// clock and chip-level reset (power-on or external pin)
	input wire logic sys_clk,
	input wire logic reset,
	// axi4-lite write
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// strap pins
	input wire logic autoMdixStrapPin,
	input wire logic [HS_W-1:0] hardStrapPins,
	// configuration loader
	input wire logic eepromPresent,
	input wire logic reloadCmd,
	input wire logic loaderValid,
	input wire logic [SS_W-1:0] loaderStraps,
	output logic digitalReset,
	output logic loaderStart,
	// transceivers: index 0 port 1, 1 port 2, 2 emulated
	input wire logic [N_PORT-1:0] portPowerDown,
	output logic [N_MOD-1:0] moduleReset,
	// configuration outputs
	output logic strapsLatched,
	output logic [HS_W-1:0] hardStraps,
	output logic [LED_N-1:0] ledEnable,
	output logic [1:0] ledFunction,
	output logic port1AutonegEn,
	output logic port1AutoMdix,
	output logic port1CrossMdix
);

	// ============================================================
	// helpers
	function automatic logic [31:0] strbMask(input logic [3:0] s);
		strbMask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : strbMask

	function automatic logic isMapped(input logic [AW-1:0] a);
		isMapped = (a == ADDR_RESET_CONTROL_REGISTER) || (a == ADDR_BASIC_P1) ||
			(a == ADDR_BASIC_P2) || (a == ADDR_BASIC_EMU) ||
			(a == ADDR_HARDWARE_CONFIGURATION_REGISTER) || (a == ADDR_LED_CONFIGURATION_REGISTER) ||
			(a == ADDR_SPEC_CTL_P1);
	endfunction : isMapped

	function automatic logic [AW-1:0] basicAddr(input int k);
		basicAddr = (k == MOD_P1) ? ADDR_BASIC_P1 :
			(k == MOD_P2) ? ADDR_BASIC_P2 : ADDR_BASIC_EMU;
	endfunction : basicAddr

	// ============================================================
	// strap pin synchronisers and one-time capture
	logic [HS_W:0] pinMeta_q;
	logic [HS_W:0] pinSync_q;
	logic [1:0] settle_q;
	logic latched_q;
	logic [SS_W-1:0] latchedSoft_q;
	logic [SS_W-1:0] softStraps_q;
	logic [HS_W-1:0] hardStraps_q;
	logic captureNow;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pinMeta_q <= '0;
			pinSync_q <= '0;
		end else begin
			pinMeta_q <= {autoMdixStrapPin, hardStrapPins};
			pinSync_q <= pinMeta_q;
		end
	end

	// capture waits for the synchronisers to fill after release
	assign captureNow = !latched_q && (settle_q == STRAP_SETTLE);

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			settle_q <= '0;
			latched_q <= 1'b0;
			latchedSoft_q <= SS_TIEOFF;
			hardStraps_q <= '0;
		end else begin
			if (!latched_q && settle_q != STRAP_SETTLE)
				settle_q <= settle_q + 2'h1;
			// only a chip reset clears latched_q, so nothing else re-latches
			if (captureNow) begin
				latched_q <= 1'b1;
				hardStraps_q <= pinSync_q[HS_W-1:0];
				latchedSoft_q <= SS_TIEOFF;
				latchedSoft_q[SS_AMDIX1] <= pinSync_q[HS_W];
			end
		end
	end

	// ============================================================
	// axi4-lite write channel
	logic awHeld_q;
	logic wHeld_q;
	logic [AW-1:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic wrEn;
	logic [31:0] wrBits;
	logic [31:0] wrMask;

	assign s_axi_awready = !awHeld_q && !bvalid_q;
	assign s_axi_wready = !wHeld_q && !bvalid_q;
	assign wrEn = awHeld_q && wHeld_q && !bvalid_q;
	// held as a net so the register updates can slice the lane mask
	assign wrMask = strbMask(wStrb_q);
	assign wrBits = wData_q & wrMask;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= '0;
			wData_q <= '0;
			wStrb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (wrEn) begin
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= isMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// ============================================================
	// digital reset and reload: restore straps without eeprom, start loader; only digital reset pulses
	logic restoreReq;
	logic applyDefaults_q;
	logic digitalReset_q;
	logic loaderStart_q;

	assign restoreReq = (wrEn && awAddr_q == ADDR_RESET_CONTROL_REGISTER &&
		wrBits[RC_DIGITAL]) || reloadCmd;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			digitalReset_q <= 1'b0;
			loaderStart_q <= 1'b0;
		end else begin
			// transceivers are not on this reset
			digitalReset_q <= wrEn && awAddr_q == ADDR_RESET_CONTROL_REGISTER &&
				wrBits[RC_DIGITAL];
			loaderStart_q <= restoreReq;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			softStraps_q <= SS_TIEOFF;
			applyDefaults_q <= 1'b0;
		end else begin
			applyDefaults_q <= captureNow || loaderValid ||
				(restoreReq && !eepromPresent);
			if (captureNow) begin
				softStraps_q <= SS_TIEOFF;
				softStraps_q[SS_AMDIX1] <= pinSync_q[HS_W];
			end else if (loaderValid) begin
				softStraps_q <= loaderStraps;
			end else if (restoreReq && !eepromPresent) begin
				softStraps_q <= latchedSoft_q;
			end
		end
	end

	// ============================================================
	// single-module resets
	logic [N_MOD-1:0] busy_q;
	logic [N_MOD-1:0] ctlBit_q;
	logic [N_MOD-1:0] basicBit_q;
	logic [RST_CNT_W-1:0] cnt_q [N_MOD];
	mrsl_cause_t cause_q [N_MOD];
	logic [15:0] basic_q [N_MOD];
	logic [N_PORT-1:0] pdPrev_q;
	logic [N_MOD-1:0] startCtl;
	logic [N_MOD-1:0] startBasic;
	logic [N_MOD-1:0] startWake;
	logic [15:0] basicDflt [N_MOD];

	always_comb begin
		for (int k = 0; k < N_MOD; k++) begin
			startCtl[k] = wrEn && awAddr_q == ADDR_RESET_CONTROL_REGISTER &&
				wrBits[RC_MOD_LSB + k];
			startBasic[k] = wrEn && awAddr_q == basicAddr(k) &&
				wrBits[BC_RESET];
			startWake[k] = (k < N_PORT) ? (pdPrev_q[k % N_PORT] &&
				!portPowerDown[k % N_PORT]) : 1'b0;
			basicDflt[k] = BC_DEFAULT;
		end
		basicDflt[MOD_P1][BC_AUTONEG] = softStraps_q[SS_AN1];
		basicDflt[MOD_P2][BC_AUTONEG] = 1'b1;
		basicDflt[MOD_EMU][BC_AUTONEG] = 1'b0;
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			pdPrev_q <= '0;
		else
			pdPrev_q <= portPowerDown;
	end

	// a start while busy is dropped: the reset already running covers it
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			busy_q <= '0;
			ctlBit_q <= '0;
			basicBit_q <= '0;
			for (int k = 0; k < N_MOD; k++) begin
				cnt_q[k] <= '0;
				cause_q[k] <= CAUSE_FULL;
			end
		end else begin
			for (int k = 0; k < N_MOD; k++) begin
				if (!busy_q[k] &&
					(startCtl[k] || startBasic[k] || startWake[k])) begin
					busy_q[k] <= 1'b1;
					ctlBit_q[k] <= 1'b1;
					basicBit_q[k] <= 1'b1;
					cnt_q[k] <= (k == MOD_EMU) ?
						RST_CNT_W'(EMU_RST_CYCLES - 1) :
						RST_CNT_W'(PORT_RST_CYCLES - 1);
					cause_q[k] <= startCtl[k] ? CAUSE_FULL :
						startBasic[k] ? CAUSE_SOFT : CAUSE_WAKE;
				end else if (busy_q[k]) begin
					if (cnt_q[k] == '0) begin
						busy_q[k] <= 1'b0;
						ctlBit_q[k] <= 1'b0;
						basicBit_q[k] <= 1'b0;
					end else begin
						cnt_q[k] <= cnt_q[k] - RST_CNT_W'(1);
					end
				end
			end
		end
	end

	// each output follows only its own module's sequence
	assign moduleReset = busy_q;

	// ============================================================
	// transceiver basic control registers
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			for (int k = 0; k < N_MOD; k++)
				basic_q[k] <= BC_DEFAULT;
		end else begin
			for (int k = 0; k < N_MOD; k++) begin
				if (busy_q[k] && cnt_q[k] == '0) begin
					if (cause_q[k] == CAUSE_FULL)
						basic_q[k] <= basicDflt[k];
					else if (cause_q[k] == CAUSE_SOFT)
						basic_q[k] <= (basic_q[k] & BC_SURVIVES_SOFT_RESET_ATTRIBUTE_MASK) |
							(basicDflt[k] & ~BC_SURVIVES_SOFT_RESET_ATTRIBUTE_MASK);
					// wake reset leaves the register alone
				end else if (applyDefaults_q) begin
					basic_q[k][BC_AUTONEG] <= basicDflt[k][BC_AUTONEG];
				end else if (!busy_q[k] && wrEn &&
					awAddr_q == basicAddr(k)) begin
					basic_q[k] <= (basic_q[k] & ~wrMask[15:0]) |
						wrBits[15:0];
				end
			end
		end
	end

	// ============================================================
	// led configuration and crossover control
	logic [LED_N-1:0] ledEn_q;
	logic [1:0] ledFun_q;
	logic [15:0] specCtl_q;
	logic autoMdix_q;
	logic crossMdix_q;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ledEn_q <= SS_TIEOFF[SS_LED_ENABLE_BITS +: LED_N];
			ledFun_q <= SS_TIEOFF[SS_LED_FUNCTION_FIELD +: 2];
		end else if (applyDefaults_q) begin
			ledEn_q <= softStraps_q[SS_LED_ENABLE_BITS +: LED_N];
			ledFun_q <= softStraps_q[SS_LED_FUNCTION_FIELD +: 2];
		end else if (wrEn && awAddr_q == ADDR_LED_CONFIGURATION_REGISTER) begin
			ledEn_q <= (ledEn_q & ~wrMask[LC_EN_LSB +: LED_N]) |
				wrBits[LC_EN_LSB +: LED_N];
			ledFun_q <= (ledFun_q & ~wrMask[LC_FUN_LSB +: 2]) |
				wrBits[LC_FUN_LSB +: 2];
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			specCtl_q <= SC_DEFAULT;
		else if (busy_q[MOD_P1] && cnt_q[MOD_P1] == '0 &&
			cause_q[MOD_P1] == CAUSE_FULL)
			specCtl_q <= SC_DEFAULT;
		else if (wrEn && awAddr_q == ADDR_SPEC_CTL_P1)
			specCtl_q <= (specCtl_q & ~wrMask[15:0]) |
				wrBits[15:0];
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			autoMdix_q <= 1'b0;
			crossMdix_q <= 1'b0;
		end else if (specCtl_q[SC_STRAPCTL]) begin
			autoMdix_q <= softStraps_q[SS_AMDIX1];
			// manual strap only counts with the auto strap low
			crossMdix_q <= !softStraps_q[SS_AMDIX1] &&
				softStraps_q[SS_MMDIX1];
		end else begin
			autoMdix_q <= specCtl_q[SC_AUTO];
			crossMdix_q <= !specCtl_q[SC_AUTO] && specCtl_q[SC_CROSS];
		end
	end

	// ============================================================
	// axi4-lite read channel
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [31:0] rdMux;

	always_comb begin
		rdMux = '0;
		case (s_axi_araddr)
			ADDR_RESET_CONTROL_REGISTER: rdMux[RC_MOD_LSB +: N_MOD] = ctlBit_q;
			ADDR_BASIC_P1: begin
				rdMux[15:0] = basic_q[MOD_P1];
				rdMux[BC_RESET] = basicBit_q[MOD_P1];
			end
			ADDR_BASIC_P2: begin
				rdMux[15:0] = basic_q[MOD_P2];
				rdMux[BC_RESET] = basicBit_q[MOD_P2];
			end
			ADDR_BASIC_EMU: rdMux[BC_RESET] = basicBit_q[MOD_EMU];
			ADDR_HARDWARE_CONFIGURATION_REGISTER: begin
				rdMux[HC_AMDIX1] = softStraps_q[SS_AMDIX1];
				rdMux[HC_LATCHED] = latched_q;
			end
			ADDR_LED_CONFIGURATION_REGISTER: begin
				rdMux[LC_EN_LSB +: LED_N] = ledEn_q;
				rdMux[LC_FUN_LSB +: 2] = ledFun_q;
			end
			ADDR_SPEC_CTL_P1: rdMux[15:0] = specCtl_q;
			default: rdMux = '0;
		endcase
	end

	assign s_axi_arready = !rvalid_q;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= rdMux;
			rresp_q <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// ============================================================
	// outputs
	assign digitalReset = digitalReset_q;
	assign loaderStart = loaderStart_q;
	assign strapsLatched = latched_q;
	assign hardStraps = hardStraps_q;
	assign ledEnable = ledEn_q;
	assign ledFunction = ledFun_q;
	assign port1AutonegEn = basic_q[MOD_P1][BC_AUTONEG];
	assign port1AutoMdix = autoMdix_q;
	assign port1CrossMdix = crossMdix_q;

endmodule : mrsl_top
